// ===== hdl/ecd_defines.vh
/*
  constants for the dispatch / writeback / bypass control block:
  stacks, ports, operation classes, latencies and bypass costs.
  assumes it is included by bare name from the design file.
*/
`ifndef ECD_DEFINES_VH
`define ECD_DEFINES_VH

// result stacks
`define ECD_STK_INT    2'h0
`define ECD_STK_VINT   2'h1
`define ECD_STK_VFP    2'h2
`define ECD_STK_LEGACY 2'h3

// operation classes (4 bits)
`define ECD_OP_ALU     4'h0
`define ECD_OP_SHIFT   4'h1
`define ECD_OP_BRANCH  4'h2
`define ECD_OP_ADDR    4'h3
`define ECD_OP_MUL     4'h4
`define ECD_OP_LDADDR  4'h5
`define ECD_OP_STADDR  4'h6
`define ECD_OP_STDATA  4'h7
`define ECD_OP_DIV     4'h8
`define ECD_OP_STRCMP  4'h9
`define ECD_OP_FADD    4'ha
`define ECD_OP_CVT     4'hb
`define ECD_OP_SHUF    4'hc
`define ECD_OP_BLEND   4'hd
`define ECD_OP_MOV     4'he

// port masks, bit n = port n
`define ECD_PM_ALU_INT 6'h23
`define ECD_PM_SHF_INT 6'h21
`define ECD_PM_P0      6'h01
`define ECD_PM_P1      6'h02
`define ECD_PM_P4      6'h10
`define ECD_PM_P5      6'h20
`define ECD_PM_P23     6'h0c
`define ECD_PM_P15     6'h22
`define ECD_PM_P015    6'h23
`define ECD_PM_P05     6'h21

// transition micro-op ports
`define ECD_XPORT_TO_VEC 3'h0
`define ECD_XPORT_TO_INT 3'h5

// execution latencies in cycles
`define ECD_LAT_MUL    3'h5
`define ECD_LAT_ONE    3'h1
`define ECD_LAT_FADD   3'h3

// writeback reservation window depth
`define ECD_WB_DEPTH   8

// bypass cost codes: bit 2 transition op, bits 1:0 added cycles
`define ECD_BYP_NONE   3'h0
`define ECD_BYP_ONE    3'h1
`define ECD_BYP_OP     3'h4
`define ECD_BYP_OP_1   3'h5

// load-return bypass delays
`define ECD_LD_DLY_INT 2'h0
`define ECD_LD_DLY_VEC 2'h1
`define ECD_LD_DLY_LEG 2'h2

// fifo
`define ECD_FIFO_DEPTH 8
`define ECD_FIFO_AW    3

`endif

// ===== hdl/ecd_fifo.v
/*
  ecd_fifo: flip-flop fifo with valid/ready on both sides.
  assumes one clock, active-low asynchronous reset and a clock enable.
*/
`timescale 1ns/1ps
module ecd_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  reg             ready_q;
  wire [AW:0]     cnt_d;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = ready_q;  // registered, so ready leaves from a flop
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // next fill level; ready is worked out from it one cycle ahead
  assign cnt_d     = (push & ~pop) ? cnt_q + 1'b1 :
                     (pop & ~push) ? cnt_q - 1'b1 : cnt_q;

  // pointers, count and storage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      ready_q <= 1'b1;
      for (i = 0; i < DEPTH; i = i + 1)
        mem_q[i] <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != DEPTH[AW:0]);
    end
  end
endmodule // ecd_fifo

// ===== hdl/ecd_dispatch.v
/*
  ecd_dispatch: dispatch port steering, per-port per-stack writeback
  bus reservation and cross-stack bypass cost for one core.
  assumes a scheduler offering up to six candidate micro-ops per cycle
  as flat vectors, and a load-return path that is buffered in a fifo.
  all inputs are taken as synchronous to clk; clk_en low freezes all state.
*/
`timescale 1ns/1ps
`include "ecd_defines.vh"

// Behaviour
// - at most six micro-ops per cycle, at most one per port
// - integer: alu 0/1/5, shift 0/5, branch 5, addr/mul 1, mem 2/3, data 4
// - vector: mul/div/strcmp port 0, fadd/cvt 1, shuffles 1/5 int, 5 float
// - four stacks: integer, vector int, vector float, legacy float; one per result
// - result returns on bus picked by dispatch port and result stack
// - same port, same stack, same writeback cycle: later micro-op takes another allowed port, or is held if none is free
// - same port micro-ops writing different stacks never collide
// - cross-stack operands add zero or one cycle of bypass delay
// - some cross-stack moves insert a transition micro-op
// - same stack zero; integer to vector needs port 0 op, legacy +1
// - vint to integer port 5 op, vfp to integer p5+1; vint-vfp 1; vint-legacy 0; vfp-legacy p5+1
// - load data: integer 0, vector 1, legacy 2 cycles
module ecd_dispatch (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        clk_en,
  input  wire [5:0]  cand_valid,
  input  wire [23:0] cand_op,
  input  wire [11:0] cand_stack,
  input  wire [11:0] cand_src_stack,
  input  wire [17:0] cand_lat,
  input  wire        ld_valid,
  input  wire [1:0]  ld_stack,
  input  wire [7:0]  ld_tag,
  output wire        ld_ready,
  output reg  [5:0]  disp_valid,
  output reg  [17:0] disp_slot,
  output reg  [11:0] disp_stack,
  output reg  [23:0] wb_bus_busy,
  output reg  [5:0]  cand_hold,
  output reg  [11:0] bypass_delay,
  output reg  [5:0]  xfer_uop,
  output reg  [17:0] xfer_port,
  output reg         ld_out_valid,
  output reg  [7:0]  ld_out_tag,
  output reg  [1:0]  ld_out_stack
);
  // writeback reservation: per port, per stack, shift window of future cycles
  // bit k of a window means the bus is taken k+1 cycles after this one;
  // buses are split by stack, so only same-stack results can ever collide
  reg  [`ECD_WB_DEPTH-1:0] resv_q [0:23];
  reg  [`ECD_WB_DEPTH-1:0] resv_d [0:23];
  // steering scratch, rebuilt from nothing every cycle
  reg  [5:0]  port_used;
  reg  [5:0]  pm;
  reg  [5:0]  grant;
  reg  [17:0] slot_d;
  reg  [3:0]  op;
  reg  [1:0]  stk;
  reg  [1:0]  src;
  reg  [2:0]  lat;
  reg  [1:0]  dly;
  reg  [5:0]  xf;
  reg  [17:0] xp;
  reg  [11:0] bd;
  reg  [23:0] busy_d;
  reg         found;
  integer     c;
  integer     p;
  integer     b;
  integer     r;

  // port mask for one class on one stack
  // store data always goes to port 4, whatever the stack
  function [5:0] port_mask;
    input [3:0] o;
    input [1:0] s;
    begin
      port_mask = 6'h00;
      if (o == `ECD_OP_STDATA)
        port_mask = `ECD_PM_P4;
      else if (s == `ECD_STK_INT) begin
        case (o)
          `ECD_OP_ALU:    port_mask = `ECD_PM_P015;
          `ECD_OP_SHIFT:  port_mask = `ECD_PM_P05;
          `ECD_OP_BRANCH: port_mask = `ECD_PM_P5;
          `ECD_OP_ADDR:   port_mask = `ECD_PM_P1;
          `ECD_OP_MUL:    port_mask = `ECD_PM_P1;
          `ECD_OP_LDADDR: port_mask = `ECD_PM_P23;
          `ECD_OP_STADDR: port_mask = `ECD_PM_P23;
          default:        port_mask = 6'h00;
        endcase
      end else begin
        case (o)
          `ECD_OP_MUL:    port_mask = `ECD_PM_P0;
          `ECD_OP_DIV:    port_mask = `ECD_PM_P0;
          `ECD_OP_STRCMP: port_mask = (s == `ECD_STK_VINT) ? `ECD_PM_P0 : 6'h00;
          `ECD_OP_FADD:   port_mask = (s == `ECD_STK_VINT) ? 6'h00 : `ECD_PM_P1;
          `ECD_OP_CVT:    port_mask = (s == `ECD_STK_VINT) ? 6'h00 : `ECD_PM_P1;
          `ECD_OP_SHUF:   port_mask = (s == `ECD_STK_VINT) ? `ECD_PM_P15 : `ECD_PM_P5;
          `ECD_OP_ALU:    port_mask = (s == `ECD_STK_VINT) ? `ECD_PM_P15 : 6'h00;
          `ECD_OP_SHIFT:  port_mask = (s == `ECD_STK_VINT) ? `ECD_PM_P05 : 6'h00;
          `ECD_OP_BLEND:  port_mask = (s == `ECD_STK_VINT) ? `ECD_PM_P15 : `ECD_PM_P05;
          `ECD_OP_MOV:    port_mask = `ECD_PM_P015;
          default:        port_mask = 6'h00;
        endcase
      end
    end
  endfunction

  // bypass cost: {needs transition op, delay cycles}
  // same-stack pairs and unlisted pairs fall through to no cost
  function [2:0] bypass_cost;
    input [1:0] from;
    input [1:0] to;
    begin
      bypass_cost = `ECD_BYP_NONE;
      case (from)
        `ECD_STK_INT: begin
          case (to)
            `ECD_STK_VINT:   bypass_cost = `ECD_BYP_OP;
            `ECD_STK_VFP:    bypass_cost = `ECD_BYP_OP;
            `ECD_STK_LEGACY: bypass_cost = `ECD_BYP_OP_1;
            default:         bypass_cost = `ECD_BYP_NONE;
          endcase
        end
        `ECD_STK_VINT: begin
          case (to)
            `ECD_STK_INT:    bypass_cost = `ECD_BYP_OP;
            `ECD_STK_VFP:    bypass_cost = `ECD_BYP_ONE;
            default:         bypass_cost = `ECD_BYP_NONE;
          endcase
        end
        `ECD_STK_VFP: begin
          case (to)
            `ECD_STK_INT:    bypass_cost = `ECD_BYP_OP_1;
            `ECD_STK_VINT:   bypass_cost = `ECD_BYP_ONE;
            `ECD_STK_LEGACY: bypass_cost = `ECD_BYP_OP_1;
            default:         bypass_cost = `ECD_BYP_NONE;
          endcase
        end
        `ECD_STK_LEGACY: begin
          case (to)
            `ECD_STK_INT:    bypass_cost = `ECD_BYP_OP_1;
            `ECD_STK_VFP:    bypass_cost = `ECD_BYP_OP_1;
            default:         bypass_cost = `ECD_BYP_NONE;
          endcase
        end
        default: bypass_cost = `ECD_BYP_NONE;
      endcase
    end
  endfunction

  // load return path buffer
  wire [9:0] lf_data;
  wire       lf_valid;
  wire       lf_pop;
  reg  [1:0] ld_dly_q;
  reg  [1:0] ld_dly_cnt_q;
  reg        ld_busy_q;
  reg  [9:0] ld_hold_q;

  // pop only when the delay stage is empty
  assign lf_pop = lf_valid & ~ld_busy_q;

  // ready is registered inside the fifo, so ld_ready leaves from a flop
  ecd_fifo #(
    .WIDTH (10),
    .DEPTH (`ECD_FIFO_DEPTH),
    .AW    (`ECD_FIFO_AW)
  ) ecd_fifo_i (
    .clk       (clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_data   ({ld_stack, ld_tag}),
    .in_valid  (ld_valid),
    .in_ready  (ld_ready),
    .out_data  (lf_data),
    .out_valid (lf_valid),
    .out_ready (lf_pop)
  );

  // load delay per consuming stack
  // the delay is extra cycles the load spends before it is presented
  always @* begin
    case (lf_data[9:8])
      `ECD_STK_INT:    dly = `ECD_LD_DLY_INT;
      `ECD_STK_LEGACY: dly = `ECD_LD_DLY_LEG;
      default:         dly = `ECD_LD_DLY_VEC;
    endcase
  end

  // greedy port selection with writeback bus check
  always @* begin
    port_used = 6'h00;
    grant     = 6'h00;
    slot_d    = 18'h0;
    xf        = 6'h00;
    xp        = 18'h0;
    bd        = 12'h0;
    busy_d    = 24'h0;
    pm        = 6'h00;
    op        = 4'h0;
    stk       = 2'h0;
    src       = 2'h0;
    lat       = 3'h0;
    found     = 1'b0;
    // window ages by one cycle before any new claim
    for (b = 0; b < 24; b = b + 1)
      resv_d[b] = {1'b0, resv_q[b][`ECD_WB_DEPTH-1:1]};
    // lower candidate index claims ports and buses first
    for (c = 0; c < 6; c = c + 1) begin
      op    = cand_op[c*4 +: 4];
      stk   = cand_stack[c*2 +: 2];
      src   = cand_src_stack[c*2 +: 2];
      lat   = cand_lat[c*3 +: 3];
      pm    = port_mask(op, stk) & ~port_used;
      found = 1'b0;
      for (p = 0; p < 6; p = p + 1) begin
        // bus index = port*4 + stack, so other stacks never clash
        if (cand_valid[c] && !found && pm[p] &&
            (lat == 3'h0 || !resv_d[p*4+stk][lat-3'h1])) begin
          found = 1'b1;
          grant[c] = 1'b1;
          port_used[p] = 1'b1;
          slot_d[c*3 +: 3] = p[2:0];
          if (lat != 3'h0)
            resv_d[p*4+stk][lat-3'h1] = 1'b1;
        end
      end
      // bypass delay is reported whether or not the candidate is granted; xfer_uop only when granted
      {xf[c], bd[c*2 +: 2]} = bypass_cost(src, stk);
      // transition op port: port 0 out of the integer stack, port 5 from any other stack
      xp[c*3 +: 3] = (src == `ECD_STK_INT) ? `ECD_XPORT_TO_VEC
                                           : `ECD_XPORT_TO_INT;
    end
    // busy flags show the bus claims for the next cycle
    for (b = 0; b < 24; b = b + 1)
      busy_d[b] = resv_d[b][0];
  end

  // registered outputs and reservation window
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // reservation window starts empty
      for (r = 0; r < 24; r = r + 1)
        resv_q[r] <= {`ECD_WB_DEPTH{1'b0}};
      disp_valid   <= 6'h00;
      disp_slot    <= 18'h0;
      disp_stack   <= 12'h0;
      wb_bus_busy  <= 24'h0;
      cand_hold    <= 6'h00;
      bypass_delay <= 12'h0;
      xfer_uop     <= 6'h00;
      xfer_port    <= 18'h0;
    end else if (clk_en) begin
      // window and outputs freeze together while clk_en is low
      for (r = 0; r < 24; r = r + 1)
        resv_q[r] <= resv_d[r];
      disp_valid   <= grant;
      disp_slot    <= slot_d;
      disp_stack   <= cand_stack;
      wb_bus_busy  <= busy_d;
      cand_hold    <= cand_valid & ~grant;
      bypass_delay <= bd;
      xfer_uop     <= xf & grant;
      xfer_port    <= xp;
    end
  end

  // load return: wait per-stack delay, then present
  // counter runs from zero up to the stored delay, then fires once
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ld_busy_q    <= 1'b0;
      ld_dly_q     <= 2'h0;
      ld_dly_cnt_q <= 2'h0;
      ld_hold_q    <= 10'h0;
      ld_out_valid <= 1'b0;
      ld_out_tag   <= 8'h0;
      ld_out_stack <= 2'h0;
    end else if (clk_en) begin
      // valid is a one-cycle pulse; tag and stack stand until the next load
      ld_out_valid <= 1'b0;
      if (lf_pop) begin
        ld_hold_q    <= lf_data;
        ld_dly_q     <= dly;
        ld_dly_cnt_q <= 2'h0;
        ld_busy_q    <= 1'b1;
      end else if (ld_busy_q) begin
        if (ld_dly_cnt_q == ld_dly_q) begin
          ld_out_valid <= 1'b1;
          ld_out_tag   <= ld_hold_q[7:0];
          ld_out_stack <= ld_hold_q[9:8];
          ld_busy_q    <= 1'b0;
        end else
          ld_dly_cnt_q <= ld_dly_cnt_q + 2'h1;
      end
    end
  end
  // a legacy consumer waits two extra cycles, a vector one a single cycle,
  // an integer one none; one load is in the delay stage at a time
endmodule // ecd_dispatch

// ===== dv/ecd_dispatch_monitor.sv
/*
  checker for ecd_dispatch: port, stack, bypass and load-return relations.
  assumes one clock and active-low asynchronous reset_n; bound below.
*/
`timescale 1ns/1ps
`include "ecd_defines.vh"
module ecd_dispatch_monitor (
  input wire        clk,
  input wire        reset_n,
  input wire        clk_en,
  input wire [5:0]  cand_valid,
  input wire [23:0] cand_op,
  input wire [11:0] cand_stack,
  input wire [11:0] cand_src_stack,
  input wire [5:0]  disp_valid,
  input wire [17:0] disp_slot,
  input wire [11:0] disp_stack,
  input wire [5:0]  cand_hold,
  input wire [11:0] bypass_delay,
  input wire [5:0]  xfer_uop,
  input wire [17:0] xfer_port,
  input wire        ld_out_valid
);
  reg     en_q;
  reg     clash;
  integer i;
  integer j;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // remembers the enable so frozen cycles are skipped
  always @(posedge clk or negedge reset_n)
    if (!reset_n) en_q <= 1'b0;
    else en_q <= clk_en;
  // flags two grants sharing one port
  always @* begin
    clash = 1'b0;
    for (i = 0; i < 6; i = i + 1)
      for (j = i + 1; j < 6; j = j + 1)
        if (disp_valid[i] && disp_valid[j] && disp_slot[i*3+:3] == disp_slot[j*3+:3])
          clash = 1'b1;
  end
  AST_ONE_PER_PORT: assert property (!clash)
    else $error("two grants on one port");
  AST_GRANT_SPLIT: assert property (en_q |->
    (disp_valid | cand_hold) == $past(cand_valid) && (disp_valid & cand_hold) == 6'h0)
    else $error("grant and hold disagree");
  AST_BRANCH_P5: assert property (en_q && disp_valid[0]
    && $past(cand_op[3:0]) == `ECD_OP_BRANCH |-> disp_slot[2:0] == 3'h5)
    else $error("branch off port 5");
  AST_INT_MUL_P1: assert property (en_q && disp_valid[0] && $past(cand_op[3:0]) == 4'h4
    && $past(cand_stack[1:0]) == 2'h0 |-> disp_slot[2:0] == 3'h1)
    else $error("integer multiply off port 1");
  AST_VEC_MUL_P0: assert property (en_q && disp_valid[0] && $past(cand_op[3:0]) == 4'h4
    && $past(cand_stack[1:0]) != 2'h0 |-> disp_slot[2:0] == 3'h0)
    else $error("vector multiply off port 0");
  AST_STACK_COPY: assert property (en_q && disp_valid[0]
    |-> disp_stack[1:0] == $past(cand_stack[1:0]))
    else $error("result stack not kept");
  AST_SAME_FREE: assert property (en_q && disp_valid[0]
    && $past(cand_src_stack[1:0]) == $past(cand_stack[1:0])
    |-> bypass_delay[1:0] == 2'h0 && !xfer_uop[0])
    else $error("same-stack forward costs");
  AST_XFER_PORT: assert property (en_q && xfer_uop[0]
    |-> disp_valid[0] &&
        xfer_port[2:0] == (($past(cand_src_stack[1:0]) == 2'h0) ? 3'h0 : 3'h5))
    else $error("transition op on bad port");
  AST_LD_PULSE: assert property (ld_out_valid && clk_en |=> !ld_out_valid)
    else $error("load return longer than one cycle");
endmodule // ecd_dispatch_monitor

bind ecd_dispatch ecd_dispatch_monitor ecd_dispatch_monitor_i (.clk(clk), .reset_n(reset_n),
  .clk_en(clk_en), .cand_valid(cand_valid), .cand_op(cand_op), .cand_stack(cand_stack),
  .cand_src_stack(cand_src_stack), .disp_valid(disp_valid), .disp_slot(disp_slot),
  .disp_stack(disp_stack), .cand_hold(cand_hold), .bypass_delay(bypass_delay),
  .xfer_uop(xfer_uop), .xfer_port(xfer_port), .ld_out_valid(ld_out_valid));

// ===== dv/ecd_ld_src.sv
/*
  load-return source model: queues pushed loads and offers them in order.
  assumes one clock, active-low reset; hold delays a fresh offer only.
*/
`timescale 1ns/1ps
module ecd_ld_src (
  input wire       clk,
  input wire       reset_n,
  input wire       ld_ready,
  input wire       hold,
  input wire       push,
  input wire [1:0] push_stack,
  input wire [7:0] push_tag,
  output reg       ld_valid,
  output reg [1:0] ld_stack,
  output reg [7:0] ld_tag
);
  reg [9:0] q[$];
  // offer held until taken; released lines toggle so stale data cannot pass
  always @(posedge clk or negedge reset_n)
    if (!reset_n) begin
      ld_valid <= 1'b0;
      ld_stack <= 2'h0;
      ld_tag <= 8'h0;
      q.delete();
    end else begin
      if (push) q.push_back({push_stack, push_tag});
      if (ld_valid && ld_ready) void'(q.pop_front());
      if (q.size() > 0 && (!hold || ld_valid)) begin
        ld_valid <= 1'b1;
        {ld_stack, ld_tag} <= q[0];
      end else begin
        ld_valid <= 1'b0;
        {ld_stack, ld_tag} <= ~{ld_stack, ld_tag};
      end
    end
endmodule // ecd_ld_src

// ===== dv/ecd_dispatch_tb_top.sv
/*
  testbench for ecd_dispatch: steering, grants, collisions, bypass, loads.
  assumes the bound checker and the load source model beside it.
*/
`timescale 1ns/1ps
module ecd_dispatch_tb_top;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [5:0] cand_valid = 6'h0;
  reg [23:0] cand_op = 24'h0;
  reg [11:0] cand_stack = 12'h0;
  reg [11:0] cand_src_stack = 12'h0;
  reg [17:0] cand_lat = 18'h0;
  reg hold = 1'b0;
  reg push = 1'b0;
  reg [1:0] push_stack = 2'h0;
  reg [7:0] push_tag = 8'h0;
  wire ld_valid, ld_ready, ld_out_valid;
  wire [1:0] ld_stack, ld_out_stack;
  wire [7:0] ld_tag, ld_out_tag;
  wire [5:0] disp_valid, cand_hold, xfer_uop;
  wire [17:0] disp_slot, xfer_port;
  wire [11:0] disp_stack, bypass_delay;
  wire [23:0] wb_bus_busy;
  integer miscompares = 0;
  integer checked = 0;
  // cost per source/consumer pair: bit3 op, bit2 port 5, bits 1:0 cycles
  localparam [63:0] COST = 64'h0d0d_d01d_010c_9880;
  always #4 clk = ~clk;
  ecd_dispatch ecd_dispatch_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .cand_valid(cand_valid), .cand_op(cand_op), .cand_stack(cand_stack),
    .cand_src_stack(cand_src_stack), .cand_lat(cand_lat), .ld_valid(ld_valid),
    .ld_stack(ld_stack), .ld_tag(ld_tag), .ld_ready(ld_ready), .disp_valid(disp_valid),
    .disp_slot(disp_slot), .disp_stack(disp_stack), .wb_bus_busy(wb_bus_busy),
    .cand_hold(cand_hold), .bypass_delay(bypass_delay), .xfer_uop(xfer_uop),
    .xfer_port(xfer_port), .ld_out_valid(ld_out_valid), .ld_out_tag(ld_out_tag),
    .ld_out_stack(ld_out_stack));
  ecd_ld_src ecd_ld_src_i (.clk(clk), .reset_n(reset_n), .ld_ready(ld_ready), .hold(hold),
    .push(push), .push_stack(push_stack), .push_tag(push_tag), .ld_valid(ld_valid),
    .ld_stack(ld_stack), .ld_tag(ld_tag));
  task close_out;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [63:0] e, input [63:0] g, input [63:0] nm);
    begin
      checked = checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  // stage one candidate; the caller picks the edge
  task put(input integer c, input [3:0] op, input [1:0] s, input [1:0] src, input [2:0] lat);
    begin
      cand_valid[c] <= 1'b1;
      cand_op[c*4+:4] <= op;
      cand_stack[c*2+:2] <= s;
      cand_src_stack[c*2+:2] <= src;
      cand_lat[c*3+:3] <= lat;
    end
  endtask
  // taking edge, then let the answer settle
  task go;
    begin
      @(posedge clk);
      cand_valid <= 6'h0;
      #1;
    end
  endtask
  task st(input [3:0] op, input [1:0] s, input [5:0] m);
    begin
      @(posedge clk);
      put(0, op, s, s, 3'h1);
      go;
      chk(1, disp_valid[0], "grant");
      chk(1, m[disp_slot[2:0]], "port");
    end
  endtask
  task six_alu;
    integer c;
    begin
      @(posedge clk);
      for (c = 0; c < 6; c = c + 1) put(c, 4'h0, 2'h0, 2'h0, 3'h1);
      go;
      chk(6'h07, disp_valid, "grants");
      chk(6'h38, cand_hold, "holds");
    end
  endtask
  task collide;
    begin
      @(posedge clk);
      put(0, 4'h4, 2'h2, 2'h2, 3'h5);
      go;
      chk(0, disp_slot[2:0], "mul p0");
      repeat (3) @(posedge clk);
      put(0, 4'hd, 2'h2, 2'h2, 3'h1);
      put(1, 4'h8, 2'h2, 2'h2, 3'h1);
      put(2, 4'h0, 2'h0, 2'h0, 3'h1);
      go;
      chk(5, disp_valid[2:0], "grants");
      chk(2, cand_hold[2:0], "held");
      chk(5, disp_slot[2:0], "blend");
      chk(0, disp_slot[8:6], "int p0");
      chk(24'h400005, wb_bus_busy, "busy");
    end
  endtask
  task byp;
    integer f, t;
    reg [3:0] e;
    begin
      for (f = 0; f < 4; f = f + 1)
        for (t = 0; t < 4; t = t + 1) begin
          e = COST[(f*4+t)*4+:4];
          @(posedge clk);
          put(0, t < 2 ? 4'h0 : 4'ha, t[1:0], f[1:0], 3'h1);
          go;
          chk(e[1:0], bypass_delay[1:0], "delay");
          chk(e[3], xfer_uop[0], "xfer");
          if (e[3]) chk(e[2] ? 5 : 0, xfer_port[2:0], "xport");
        end
    end
  endtask
  task ld_lat(input [1:0] s, input integer n);
    integer k, t0;
    begin
      @(posedge clk);
      push <= 1'b1;
      push_stack <= s;
      push_tag <= {6'h2a, s};
      @(posedge clk);
      push <= 1'b0;
      k = 0;
      t0 = 0;
      while (k < 20 && ld_out_valid !== 1'b1) begin
        @(posedge clk);
        k = k + 1;
        if (ld_valid && ld_ready) t0 = k;
      end
      chk(n, k - t0, "ld lat");
      chk(s, ld_out_stack, "ld stk");
      chk({6'h2a, s}, ld_out_tag, "ld tag");
    end
  endtask
  task ld_fill;
    integer k, got;
    reg low;
    begin
      hold <= 1'b1;
      push_stack <= 2'h3;
      for (k = 0; k < 12; k = k + 1) begin
        @(posedge clk);
        push <= 1'b1;
        push_tag <= k[7:0];
      end
      @(posedge clk);
      push <= 1'b0;
      hold <= 1'b0;
      got = 0;
      low = 1'b0;
      for (k = 0; k < 200; k = k + 1) begin
        @(posedge clk);
        if (ld_ready === 1'b0) low = 1'b1;
        if (ld_out_valid === 1'b1) begin
          chk(got, ld_out_tag, "order");
          got = got + 1;
        end
      end
      chk(1, low, "full");
      chk(12, got, "count");
    end
  endtask
  // about 320 cycles of tests; cut a hang well beyond that
  initial begin
    #100000;
    miscompares = miscompares + 1;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    st(4'h0, 2'h0, 6'h23);
    st(4'h1, 2'h0, 6'h21);
    st(4'h2, 2'h0, 6'h20);
    st(4'h3, 2'h0, 6'h02);
    st(4'h4, 2'h0, 6'h02);
    st(4'h5, 2'h0, 6'h0c);
    st(4'h6, 2'h0, 6'h0c);
    st(4'h7, 2'h0, 6'h10);
    st(4'h4, 2'h2, 6'h01);
    st(4'h8, 2'h2, 6'h01);
    st(4'h9, 2'h1, 6'h01);
    st(4'ha, 2'h2, 6'h02);
    st(4'hb, 2'h2, 6'h02);
    st(4'hc, 2'h1, 6'h22);
    st(4'hc, 2'h2, 6'h20);
    $display("steering done");
    six_alu;
    $display("six alu done");
    collide;
    $display("collision done");
    byp;
    $display("bypass done");
    ld_lat(2'h0, 3);
    ld_lat(2'h1, 4);
    ld_lat(2'h2, 4);
    ld_lat(2'h3, 5);
    $display("load latency done");
    ld_fill;
    $display("load fill done");
    close_out;
  end
endmodule // ecd_dispatch_tb_top
